// file: hdl/bcm_fifo.sv
// Dual-clock frame FIFO with gray-coded pointers.
// Assumes DEPTH is a power of two and each side has its own synchronous reset.
`timescale 1ns/1ns
`default_nettype none
module bcm_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input  wire logic   wr_clk,   // Filling side clock
    input  wire logic   wr_rst_n, // Filling side reset, active low
    input  wire logic   rd_clk,   // Draining side clock
    input  wire logic   rd_rst_n, // Draining side reset, active low
    bcm_fifo_if.store   fifo      // Handshake bundle
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW:0] bin;
        logic [AW:0] gray;
        logic [AW:0] peer_meta;
        logic [AW:0] peer_sync;
    } bcm_ptr_t;

    function automatic logic [AW:0] to_gray(input logic [AW:0] b);
        return b ^ (b >> 1);
    endfunction

    logic [WIDTH-1:0] mem [DEPTH];
    bcm_ptr_t         wr;
    bcm_ptr_t         next_wr;
    bcm_ptr_t         rd;
    bcm_ptr_t         next_rd;
    logic             full;
    logic             empty;

    // Full when the write pointer has lapped the read pointer once
    assign full           = wr.gray == {~wr.peer_sync[AW:AW-1], wr.peer_sync[AW-2:0]};
    assign empty          = rd.gray == rd.peer_sync;
    assign fifo.wr_ready  = ~full;
    assign fifo.rd_valid  = ~empty;
    assign fifo.rd_data   = mem[rd.bin[AW-1:0]];

    always_comb begin
        next_wr           = wr;
        next_wr.peer_meta = rd.gray;
        next_wr.peer_sync = wr.peer_meta;
        if (fifo.wr_valid && !full) begin
            next_wr.bin  = wr.bin + 1'b1;
            next_wr.gray = to_gray(next_wr.bin);
        end
        if (!wr_rst_n) begin
            next_wr = '0;
        end
    end

    always_ff @(posedge wr_clk) begin
        wr <= next_wr;
        if (wr_rst_n && fifo.wr_valid && !full) begin
            mem[wr.bin[AW-1:0]] <= fifo.wr_data;
        end
    end

    always_comb begin
        next_rd           = rd;
        next_rd.peer_meta = wr.gray;
        next_rd.peer_sync = rd.peer_meta;
        if (fifo.rd_ready && !empty) begin
            next_rd.bin  = rd.bin + 1'b1;
            next_rd.gray = to_gray(next_rd.bin);
        end
        if (!rd_rst_n) begin
            next_rd = '0;
        end
    end

    always_ff @(posedge rd_clk) begin
        rd <= next_rd;
    end
endmodule
`default_nettype wire

// file: hdl/bcm_fifo_if.sv
// Handshake bundle between the link logic and the frame FIFO.
// Write side lives on the link clock, read side on the reference clock.
`timescale 1ns/1ns
`default_nettype none
interface bcm_fifo_if #(parameter int WIDTH = 16);
    logic             wr_valid;
    logic             wr_ready;
    logic [WIDTH-1:0] wr_data;
    logic             rd_valid;
    logic             rd_ready;
    logic [WIDTH-1:0] rd_data;

    modport producer (output wr_valid, output wr_data, input wr_ready,
                      input rd_valid, input rd_data, output rd_ready);
    modport store    (input wr_valid, input wr_data, output wr_ready,
                      output rd_valid, output rd_data, input rd_ready);
endinterface
`default_nettype wire

// file: hdl/bcm_mux.sv
// Base-board end of the backplane control-signal multiplexer.
// Assumes link_clk is the board's own 10 MHz bit clock source, free running,
// and that the far end frames itself on frame_sync_n.
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// R01: Outgoing control levels leave one per slot on a single serial line.
// R02: Far end returns its control and status levels one per slot.
// R03: Both data lines move one bit per cycle of the 10 MHz bit clock.
// R04: Each direction repeats a sixteen-slot frame, slots 0 to 15.
// R05: Frame sync goes low for exactly one bit, in slot 15 only.
// R06: Far end aligns its slot count using frame sync as slot 15.
// R07: Slots 0-10 carry port 3/4 controls, id request, port 1/2 DTR.
// R08: Return slots carry port 3/4 status with id bits, then port 1/2 status.
// R09: Pure hardware path; no software-visible registers or commands.
// R10: Reserved slots idle; every received slot held in parallel until next frame.
// R11: Board sources bit clock; send on one edge, sample on the other.
module bcm_mux (
    input  wire logic ref_clk,            // 100 MHz system clock
    input  wire logic rst_n,              // Synchronous reset, active low
    input  wire logic link_clk,           // Bit clock source for the link
    input  wire logic status_freeze,      // Hold status outputs, stall draining
    input  wire logic port3_rts,          // Port 3 request to send
    input  wire logic port3_dtr,          // Port 3 terminal ready
    input  wire logic port3_local_loop,   // Port 3 local loopback
    input  wire logic module_mode_select, // Shares slot with port 3 local loop
    input  wire logic port3_remote_loop,  // Port 3 remote loopback
    input  wire logic port4_rts,          // Port 4 request to send
    input  wire logic port4_dtr,          // Port 4 terminal ready
    input  wire logic port4_local_loop,   // Port 4 local loopback
    input  wire logic port4_remote_loop,  // Port 4 remote loopback
    input  wire logic id_request_n,       // Module id request, active low
    input  wire logic port1_dtr,          // Port 1 terminal ready
    input  wire logic port2_dtr,          // Port 2 terminal ready
    input  wire logic mux_in_line,        // Serial line from the module
    output logic      mux_bit_clock,      // Forwarded bit clock
    output logic      mux_out_line,       // Serial line to the module
    output logic      frame_sync_n,       // Frame marker, active low
    output logic      port3_cts,          // Port 3 clear to send
    output logic      port3_dsr,          // Port 3 set ready
    output logic      port3_dcd,          // Port 3 carrier detect
    output logic      port3_test_mode,    // Port 3 test mode
    output logic      port3_ri,           // Port 3 ring indicator
    output logic      port4_cts,          // Port 4 clear to send
    output logic      port4_dsr,          // Port 4 set ready
    output logic      port4_dcd,          // Port 4 carrier detect
    output logic      port4_test_mode,    // Port 4 test mode
    output logic      port4_ri,           // Port 4 ring indicator
    output logic      port1_ri,           // Port 1 ring indicator
    output logic      port1_dsr,          // Port 1 set ready
    output logic      port1_dcd,          // Port 1 carrier detect
    output logic      port2_ri,           // Port 2 ring indicator
    output logic      port2_dsr,          // Port 2 set ready
    output logic      port2_dcd,          // Port 2 carrier detect
    output logic      module_id_bit0,     // Module id bit 0
    output logic      module_id_bit1,     // Module id bit 1
    output logic      module_id_bit2,     // Module id bit 2
    output logic      module_id_bit3      // Module id bit 3
);
    typedef struct packed {
        logic                       rst_meta;
        logic                       rst_ok;
        logic [bcm_pkg::TX_W-1:0]   tx_meta;
        logic [bcm_pkg::TX_W-1:0]   tx_sync;
        logic [bcm_pkg::TX_W-1:0]   tx_word;
        logic [bcm_pkg::SLOT_W-1:0] slot;
        logic                       out_bit;
        logic                       sync_n;
        logic [bcm_pkg::SLOTS-1:0]  rx_word;
        logic [bcm_pkg::SLOTS-1:0]  frame_buf;
        logic                       push_pend;
        logic                       armed;
    } bcm_link_t;

    typedef struct packed {
        logic [bcm_pkg::SLOTS-1:0] rx_hold;
    } bcm_ref_t;

    bcm_link_t                l;
    bcm_link_t                next_l;
    bcm_ref_t                 r;
    bcm_ref_t                 next_r;
    logic                     in_sample;
    logic                     in_frame_end;
    logic [bcm_pkg::TX_W-1:0] tx_par;
    logic [3:0]               slot_nx;

    bcm_fifo_if #(.WIDTH(bcm_pkg::FIFO_WIDTH)) frames ();

    bcm_fifo #(
        .WIDTH (bcm_pkg::FIFO_WIDTH),
        .DEPTH (bcm_pkg::FIFO_DEPTH)
    ) u_fifo (
        .wr_clk   (link_clk),
        .wr_rst_n (l.rst_ok),
        .rd_clk   (ref_clk),
        .rd_rst_n (rst_n),
        .fifo     (frames)
    );

    // Board drives the bit clock straight from its source [R11]
    assign mux_bit_clock = link_clk;

    always_comb begin
        tx_par                       = '0;
        tx_par[bcm_pkg::TX_P3_RTS]   = port3_rts;
        tx_par[bcm_pkg::TX_P3_DTR]   = port3_dtr;
        tx_par[bcm_pkg::TX_P3_LOOP]  = port3_local_loop | module_mode_select;
        tx_par[bcm_pkg::TX_P3_RLOOP] = port3_remote_loop;
        tx_par[bcm_pkg::TX_P4_RTS]   = port4_rts;
        tx_par[bcm_pkg::TX_P4_DTR]   = port4_dtr;
        tx_par[bcm_pkg::TX_P4_LOOP]  = port4_local_loop;
        tx_par[bcm_pkg::TX_P4_RLOOP] = port4_remote_loop;
        tx_par[bcm_pkg::TX_ID_REQUEST_N]    = id_request_n;
        tx_par[bcm_pkg::TX_P1_DTR]   = port1_dtr;
        tx_par[bcm_pkg::TX_P2_DTR]   = port2_dtr;
    end

    // Return line sampled mid-bit, opposite to the launch edge [R11]
    always_ff @(negedge link_clk) begin
        in_sample <= mux_in_line;
    end

    assign slot_nx      = l.slot + 4'h1;
    assign in_frame_end = l.slot == bcm_pkg::SYNC_SLOT;

    always_comb begin
        next_l          = l;
        next_l.rst_meta = rst_n;
        next_l.rst_ok   = l.rst_meta;
        next_l.tx_meta  = tx_par;
        next_l.tx_sync  = l.tx_meta;
        if (!l.rst_ok) begin
            next_l.slot      = bcm_pkg::SYNC_SLOT;
            next_l.out_bit   = bcm_pkg::IDLE_LEVEL;
            next_l.sync_n    = 1'b1;
            next_l.tx_word   = {bcm_pkg::TX_W{bcm_pkg::IDLE_LEVEL}};
            next_l.rx_word   = '0;
            next_l.frame_buf = '0;
            next_l.push_pend = 1'b0;
            next_l.armed     = 1'b0;
        end else begin
            next_l.slot    = slot_nx;                                    // [R03] [R04]
            // Snapshot in a reserved slot so a frame never mixes old and new levels
            if (slot_nx == bcm_pkg::SYNC_SLOT) begin
                next_l.tx_word = l.tx_sync;
            end
            next_l.out_bit = bcm_pkg::tx_slot_bit(l.tx_word, slot_nx);  // [R01] [R07] [R10]
            next_l.sync_n  = slot_nx != bcm_pkg::SYNC_SLOT;              // [R05]
            next_l.rx_word[l.slot] = in_sample;                          // [R10]
            if (l.push_pend && frames.wr_ready) begin
                next_l.push_pend = 1'b0;
            end
            // A full FIFO with a frame still pending stalls capture: the new frame is skipped, not overwritten
            if (in_frame_end && l.armed && (!l.push_pend || frames.wr_ready)) begin
                next_l.frame_buf = {in_sample, l.rx_word[bcm_pkg::SLOTS-2:0]};
                next_l.push_pend = 1'b1;
            end
            if (in_frame_end) begin
                next_l.armed = 1'b1;
            end
        end
    end

    always_ff @(posedge link_clk) begin
        l <= next_l;
    end

    assign mux_out_line    = l.out_bit;
    assign frame_sync_n    = l.sync_n;
    assign frames.wr_valid = l.push_pend;
    assign frames.wr_data  = l.frame_buf;
    assign frames.rd_ready = ~status_freeze;

    always_comb begin
        next_r = r;
        if (frames.rd_valid && frames.rd_ready) begin
            next_r.rx_hold = frames.rd_data;                             // [R10]
        end
        if (!rst_n) begin
            next_r.rx_hold = bcm_pkg::RX_HOLD_RST;
        end
    end

    always_ff @(posedge ref_clk) begin
        r <= next_r;
    end

    // Status appears as plain levels, as if wired directly [R09]
    assign port3_cts       = r.rx_hold[bcm_pkg::RX_P3_CTS];
    assign port3_dsr       = r.rx_hold[bcm_pkg::RX_P3_DSR];
    assign port3_dcd       = r.rx_hold[bcm_pkg::RX_P3_DCD];
    assign port3_test_mode = r.rx_hold[bcm_pkg::RX_P3_TM];
    assign port3_ri        = r.rx_hold[bcm_pkg::RX_P3_RI];
    assign port4_cts       = r.rx_hold[bcm_pkg::RX_P4_CTS];
    assign port4_dsr       = r.rx_hold[bcm_pkg::RX_P4_DSR];
    assign port4_dcd       = r.rx_hold[bcm_pkg::RX_P4_DCD];
    assign port4_test_mode = r.rx_hold[bcm_pkg::RX_P4_TM];
    assign port4_ri        = r.rx_hold[bcm_pkg::RX_P4_RI];
    assign port1_ri        = r.rx_hold[bcm_pkg::RX_P1_RI];
    assign port1_dsr       = r.rx_hold[bcm_pkg::RX_P1_DSR];
    assign port1_dcd       = r.rx_hold[bcm_pkg::RX_P1_DCD];
    assign port2_ri        = r.rx_hold[bcm_pkg::RX_P2_RI];
    assign port2_dsr       = r.rx_hold[bcm_pkg::RX_P2_DSR];
    assign port2_dcd       = r.rx_hold[bcm_pkg::RX_P2_DCD];
    // Id bits share slots with set-ready and test-mode
    assign module_id_bit0  = r.rx_hold[bcm_pkg::RX_P3_TM];
    assign module_id_bit1  = r.rx_hold[bcm_pkg::RX_P3_DSR];
    assign module_id_bit2  = r.rx_hold[bcm_pkg::RX_P4_TM];
    assign module_id_bit3  = r.rx_hold[bcm_pkg::RX_P4_DSR];

    sequence s_sync_bit;
        !frame_sync_n ##1 frame_sync_n;
    endsequence

    sequence s_quiet_run;
        frame_sync_n [*8];
    endsequence

    property p_sync_period;
        @(posedge link_clk) disable iff (!l.rst_ok)
        $fell(frame_sync_n) |-> ##16 $fell(frame_sync_n);
    endproperty

    property p_sync_single;
        @(posedge link_clk) disable iff (!l.rst_ok)
        $fell(frame_sync_n) |-> s_sync_bit ##0 s_quiet_run;
    endproperty

    AST_SYNC_PERIOD: assert property (p_sync_period) // [R04]
        else $error("frame sync not 16 bits apart");

    AST_SYNC_SINGLE: assert property (p_sync_single) // [R05]
        else $error("frame sync low longer than one bit");

    AST_SYNC_AT_SLOT15: assert property ( // [R05]
        @(posedge link_clk) disable iff (!l.rst_ok)
        $fell(frame_sync_n) |-> l.slot == bcm_pkg::SYNC_SLOT)
        else $error("frame sync outside slot 15");

    AST_SLOT_STEP: assert property ( // [R03]
        @(posedge link_clk) disable iff (!l.rst_ok)
        $past(l.rst_ok) |-> l.slot == $past(l.slot) + 4'h1)
        else $error("slot counter did not advance by one");

    AST_RESERVED_IDLE: assert property ( // [R10]
        @(posedge link_clk) disable iff (!l.rst_ok)
        (l.slot > bcm_pkg::LAST_TX_SLOT) |-> mux_out_line == bcm_pkg::IDLE_LEVEL)
        else $error("reserved slot not idle");

    AST_FIRST_SLOT_DATA: assert property ( // [R07]
        @(posedge link_clk) disable iff (!l.rst_ok)
        in_frame_end |=> mux_out_line == $past(l.tx_word[bcm_pkg::TX_P3_RTS]))
        else $error("slot 0 does not carry port 3 rts");

    AST_ID_REQUEST_N_SLOT: assert property ( // [R01]
        @(posedge link_clk) disable iff (!l.rst_ok)
        (l.slot == 4'(bcm_pkg::TX_ID_REQUEST_N)) |-> mux_out_line == l.tx_word[bcm_pkg::TX_ID_REQUEST_N])
        else $error("id request slot carries wrong level");

    AST_PUSH_AFTER_FRAME: assert property ( // [R10]
        @(posedge link_clk) disable iff (!l.rst_ok)
        $rose(l.push_pend) |-> l.slot == bcm_pkg::SLOT_FIRST
            && l.frame_buf[bcm_pkg::RX_P2_DCD] == $past(in_sample))
        else $error("frame pushed at wrong time or wrong last bit");

    AST_HOLD_STEADY: assert property ( // [R10]
        @(posedge ref_clk) disable iff (!rst_n)
        !(frames.rd_valid && frames.rd_ready) |=> $stable(r.rx_hold))
        else $error("held status changed without a new frame");

    sequence s_frame_read;
        frames.rd_valid && frames.rd_ready;
    endsequence

    // The far end frames on this pulse alone, so a stray low would slip its count
    AST_SYNC_ONLY_SLOT15: assert property ( // [R05]
        @(posedge link_clk) disable iff (!l.rst_ok)
        (l.slot != bcm_pkg::SYNC_SLOT) |-> frame_sync_n)
        else $error("frame sync low outside slot 15");

    AST_SNAPSHOT_AT_SYNC: assert property ( // [R07]
        @(posedge link_clk) disable iff (!l.rst_ok)
        $past(l.rst_ok) && (l.slot == bcm_pkg::SYNC_SLOT) |-> l.tx_word == $past(l.tx_sync))
        else $error("outgoing word not taken at slot 15");

    AST_RX_SLOT_CAPTURE: assert property ( // [R10]
        @(posedge link_clk) disable iff (!l.rst_ok)
        $past(l.rst_ok) && (l.slot != bcm_pkg::SLOT_FIRST) |-> l.rx_word[l.slot - 4'h1] == $past(in_sample))
        else $error("received bit stored in wrong slot");

    AST_HOLD_LOADS_FRAME: assert property ( // [R10]
        @(posedge ref_clk) disable iff (!rst_n)
        s_frame_read |=> r.rx_hold == $past(frames.rd_data))
        else $error("held status not loaded from the read frame");

    AST_FREEZE_HOLDS: assert property ( // [R10]
        @(posedge ref_clk) disable iff (!rst_n)
        status_freeze |=> $stable(r.rx_hold))
        else $error("held status changed while frozen");

    AST_RESET_CLEARS_HOLD: assert property ( // [R10]
        @(posedge ref_clk)
        !rst_n |=> r.rx_hold == bcm_pkg::RX_HOLD_RST)
        else $error("held status not cleared by reset");
endmodule
`default_nettype wire

// file: hdl/bcm_pkg.sv
// Constants shared by the backplane control-signal multiplexer and its FIFO.
// Assumes a 10 MHz link bit clock and a 16-slot frame in both directions.
package bcm_pkg;
    localparam int          SLOTS         = 16;
    localparam int          SLOT_W        = 4;
    localparam int          TX_W          = 11;
    localparam int          FIFO_WIDTH    = 16;
    localparam int          FIFO_DEPTH    = 4;
    localparam int          BIT_CLOCK_MHZ = 10;

    localparam logic [3:0]  SLOT_FIRST    = 4'h0;
    localparam logic [3:0]  SYNC_SLOT     = 4'hf;
    localparam logic [3:0]  LAST_TX_SLOT  = 4'ha;

    localparam logic        IDLE_LEVEL    = 1'b1;
    localparam logic [15:0] RX_HOLD_RST   = 16'h0000;

    // Outgoing slot positions
    localparam int TX_P3_RTS   = 0;
    localparam int TX_P3_DTR   = 1;
    localparam int TX_P3_LOOP  = 2;
    localparam int TX_P3_RLOOP = 3;
    localparam int TX_P4_RTS   = 4;
    localparam int TX_P4_DTR   = 5;
    localparam int TX_P4_LOOP  = 6;
    localparam int TX_P4_RLOOP = 7;
    localparam int TX_ID_REQUEST_N    = 8;
    localparam int TX_P1_DTR   = 9;
    localparam int TX_P2_DTR   = 10;

    // Incoming slot positions
    localparam int RX_P3_CTS   = 0;
    localparam int RX_P3_DSR   = 1;
    localparam int RX_P3_DCD   = 2;
    localparam int RX_P3_TM    = 3;
    localparam int RX_P3_RI    = 4;
    localparam int RX_P4_CTS   = 5;
    localparam int RX_P4_DSR   = 6;
    localparam int RX_P4_DCD   = 7;
    localparam int RX_P4_TM    = 8;
    localparam int RX_P4_RI    = 9;
    localparam int RX_P1_RI    = 10;
    localparam int RX_P1_DSR   = 11;
    localparam int RX_P1_DCD   = 12;
    localparam int RX_P2_RI    = 13;
    localparam int RX_P2_DSR   = 14;
    localparam int RX_P2_DCD   = 15;

    // Level sent in a given slot; reserved slots stay idle
    function automatic logic tx_slot_bit(input logic [TX_W-1:0] word, input logic [3:0] slot);
        logic b;
        b = IDLE_LEVEL;
        if (slot <= LAST_TX_SLOT) begin
            b = word[slot];
        end
        return b;
    endfunction
endpackage

// file: tb/bcm_far_end.sv
// Behavioural model of the far (module) end of the control-signal link.
// Assumes the board end sources the bit clock and the frame marker.
`timescale 1ns/1ns
`default_nettype none
module bcm_far_end (
    input  wire logic        bit_clk,   // Bit clock from the board
    input  wire logic        sync_n,    // Frame marker, active low
    input  wire logic        out_line,  // Serial line from the board
    input  wire logic [15:0] ret_word,  // Levels sent back, bit s in slot s
    output logic             in_line,   // Serial line to the board
    output logic      [15:0] got_word,  // Last whole frame received
    output logic             frame_done // Toggles at each frame end
);
    logic [3:0]  slot;
    logic [15:0] shift;

    initial begin
        slot = 4'h0;
        shift = 16'h0000;
        in_line = 1'b0;
        got_word = 16'h0000;
        frame_done = 1'b0;
    end

    // Launch on rising edge so the board can sample on falling
    always @(posedge bit_clk) begin
        slot <= slot + 4'h1;
        in_line <= ret_word[slot + 4'h1];
    end

    // Marker pins the count to slot 15, so a slip heals in one frame
    always @(negedge bit_clk) begin
        shift[slot] = out_line;
        if (!sync_n) begin
            got_word <= {out_line, shift[14:0]};
            frame_done <= ~frame_done;
            slot <= 4'hf;
        end
    end
endmodule
`default_nettype wire

// file: tb/bcm_mux_tb.sv
// Self-checking bench for the board end of the control-signal multiplexer.
// Assumes the far-end model answers every frame; drives inputs on falling ref_clk.
`timescale 1ns/1ns
`default_nettype none
module bcm_mux_tb;
    logic        ref_clk;
    logic        link_clk;
    logic        rst_n;
    logic        status_freeze;
    logic [11:0] tx_in;
    logic [15:0] ret_word;
    logic [31:0] rnd;
    logic [15:0] exp_tx[$];
    logic [19:0] exp_st[$];
    int          mismatches;
    int          checks_done;
    int          cycles;
    int          gap;
    logic        armed;
    wire  [15:0] got_word;
    wire         frame_done;
    wire         mux_bit_clock;
    wire         mux_out_line;
    wire         mux_in_line;
    wire         frame_sync_n;
    wire  [19:0] st;

    initial ref_clk = 1'b0;
    always #5 ref_clk = ~ref_clk;
    // Offset start keeps the link clock out of phase with ref_clk
    initial begin
        link_clk = 1'b0;
        #3;
        forever #6 link_clk = ~link_clk;
    end

    bcm_mux bcm_mux_inst (
        .ref_clk(ref_clk), .rst_n(rst_n), .link_clk(link_clk), .status_freeze(status_freeze),
        .port3_rts(tx_in[0]), .port3_dtr(tx_in[1]), .port3_local_loop(tx_in[2]),
        .module_mode_select(tx_in[3]), .port3_remote_loop(tx_in[4]), .port4_rts(tx_in[5]),
        .port4_dtr(tx_in[6]), .port4_local_loop(tx_in[7]), .port4_remote_loop(tx_in[8]),
        .id_request_n(tx_in[9]), .port1_dtr(tx_in[10]), .port2_dtr(tx_in[11]),
        .mux_in_line(mux_in_line), .mux_bit_clock(mux_bit_clock), .mux_out_line(mux_out_line),
        .frame_sync_n(frame_sync_n), .port3_cts(st[0]), .port3_dsr(st[1]), .port3_dcd(st[2]),
        .port3_test_mode(st[3]), .port3_ri(st[4]), .port4_cts(st[5]), .port4_dsr(st[6]),
        .port4_dcd(st[7]), .port4_test_mode(st[8]), .port4_ri(st[9]), .port1_ri(st[10]),
        .port1_dsr(st[11]), .port1_dcd(st[12]), .port2_ri(st[13]), .port2_dsr(st[14]),
        .port2_dcd(st[15]), .module_id_bit0(st[16]), .module_id_bit1(st[17]),
        .module_id_bit2(st[18]), .module_id_bit3(st[19])
    );

    bcm_far_end bcm_far_end_inst (
        .bit_clk(mux_bit_clock), .sync_n(frame_sync_n), .out_line(mux_out_line),
        .ret_word(ret_word), .in_line(mux_in_line), .got_word(got_word), .frame_done(frame_done)
    );

    task automatic check(input logic [19:0] seen, input logic [19:0] want, input string what);
        checks_done++;
        if (seen !== want) begin
            mismatches++;
            $display("ERROR t=%0t %s seen %h want %h", $time, what, seen, want);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    function automatic logic [15:0] tx_exp(input logic [11:0] t);
        logic [15:0] w;
        w = 16'hffff;
        w[bcm_pkg::TX_P3_RTS] = t[0];
        w[bcm_pkg::TX_P3_DTR] = t[1];
        w[bcm_pkg::TX_P3_LOOP] = t[2] | t[3];
        w[bcm_pkg::TX_P3_RLOOP] = t[4];
        w[bcm_pkg::TX_P4_RTS] = t[5];
        w[bcm_pkg::TX_P4_DTR] = t[6];
        w[bcm_pkg::TX_P4_LOOP] = t[7];
        w[bcm_pkg::TX_P4_RLOOP] = t[8];
        w[bcm_pkg::TX_ID_REQUEST_N] = t[9];
        w[bcm_pkg::TX_P1_DTR] = t[10];
        w[bcm_pkg::TX_P2_DTR] = t[11];
        return w;
    endfunction

    // Hold levels three frames so they surely passed the snapshot, then note results
    task automatic apply(input logic [11:0] t, input logic [15:0] r, input logic [15:0] sr, input string name);
        @(negedge ref_clk);
        tx_in = t;
        ret_word = r;
        repeat (3) @(frame_done);
        @(negedge ref_clk);
        exp_tx.push_back(tx_exp(t));
        exp_st.push_back({sr[6], sr[8], sr[1], sr[3], sr});
        repeat (2) @(frame_done);
        $display("test %s done", name);
    endtask

    task automatic do_reset();
        @(negedge ref_clk);
        rst_n = 1'b0;
        repeat (20) @(negedge ref_clk);
        check(st, 20'h00000, "status in reset");
        check({18'h00000, mux_out_line, frame_sync_n}, 20'h00003, "lines in reset");
        rst_n = 1'b1;
    endtask

    always @(frame_done) begin
        if (exp_tx.size() > 0) check({4'h0, got_word}, {4'h0, exp_tx.pop_front()}, "serial frame");
        if (exp_st.size() > 0) check(st, exp_st.pop_front(), "status levels");
    end

    always @(negedge link_clk) begin
        #2;
        check({19'h00000, mux_bit_clock}, 20'h00000, "bit clock");
        if (!rst_n) begin
            armed = 1'b0;
        end else if (!frame_sync_n) begin
            check({19'h00000, mux_out_line}, 20'h00001, "sync slot idle");
            if (armed) check(gap[19:0], 20'h00010, "frame length");
            gap = 1;
            armed = 1'b1;
        end else begin
            gap++;
        end
    end

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            wrap_up();
        end
    end

    initial begin
        rst_n = 1'b0;
        status_freeze = 1'b0;
        tx_in = 12'h000;
        ret_word = 16'h0000;
        mismatches = 0;
        checks_done = 0;
        cycles = 0;
        gap = 0;
        armed = 1'b0;
        rnd = $urandom(17264);
        do_reset();
        for (int i = 0; i < 16; i++) begin
            apply(12'h001 << (i % 12), 16'h0001 << i, 16'h0001 << i, "walking one");
        end
        repeat (8) begin
            rnd = $urandom;
            apply(rnd[11:0], rnd[27:12], rnd[27:12], "random");
        end
        // Freeze stalls draining so the FIFO fills and later frames drop
        @(negedge ref_clk);
        status_freeze = 1'b1;
        apply(12'hfff, 16'h5a5a, ret_word, "frozen");
        @(negedge ref_clk);
        status_freeze = 1'b0;
        apply(12'h000, 16'h5a5a, 16'h5a5a, "drained");
        do_reset();
        apply(12'h0a5, 16'hc3c3, 16'hc3c3, "after reset");
        wrap_up();
    end
endmodule
`default_nettype wire
